//--- design/cpu_hold_maskable_irq_copro_ctl.sv
// hold arbitration, coprocessor handshake, interrupt inputs and reset pin logic
// assumes the core presents bus values and instruction classes on clk_sys_in
`timescale 1ns/1ns

module cpu_hold_maskable_irq_copro_ctl
	import cpu_ctl_pkg::*;
(
	// clock and system reset
	input  wire logic         clk_sys_in,
	input  wire logic         reset_n_in,
	// device pins, inputs
	input  wire logic         cpu_reset_in,
	input  wire logic         hold_req_in,
	input  wire logic         copro_operand_request_in,
	input  wire logic         copro_busy_n_in,
	input  wire logic         copro_error_n_in,
	input  wire logic         maskable_irq_in,
	input  wire logic         nmi_in,
	input  wire logic [7:0]   data_low_in,
	// device pins, outputs
	output logic              bus_hold_grant_out,
	output bus_ctl_t          bus_pins_out,
	output logic              bus_oe_n_out,
	output logic [31:0]       data_pins_out,
	output logic              data_oe_n_out,
	// core side, bus
	input  wire bus_ctl_t     core_bus_in,
	input  wire logic [31:0]  core_data_in,
	input  wire logic         core_data_drive_in,
	input  wire logic         core_bus_idle_in,
	// core side, coprocessor
	input  wire logic         copro_instr_valid_in,
	input  wire copro_instr_t copro_instr_kind_in,
	input  wire logic         copro_dir_in,
	input  wire logic [29:0]  copro_addr_in,
	output logic              copro_go_out,
	output logic              copro_exc_out,
	output logic              copro_xfer_req_out,
	output logic              copro_xfer_dir_out,
	output logic [29:0]       copro_xfer_addr_out,
	// core side, interrupts
	input  wire logic         irq_enable_flag_in,
	input  wire logic         interrupt_return_instr_in,
	input  wire logic         inta_cycle_done_in,
	output logic              inta_cycle_out,
	output logic              inta_second_out,
	output logic              vector_valid_out,
	output logic [7:0]        vector_out,
	// core side, reset results
	output logic              selftest_req_out,
	output logic              proc_phase_out
);

	// ---------------------------------------------------------------
	// synchronisers and sampled synchronous pins
	// ---------------------------------------------------------------
	logic [ASYNC_LANES-1:0] async_raw;
	logic [ASYNC_LANES-1:0] sync1_reg;
	logic [ASYNC_LANES-1:0] sync2_reg;
	logic                   reset_q_reg;
	logic                   hold_q_reg;
	logic                   nmi_prev_reg;

	assign async_raw = {nmi_in, maskable_irq_in, !copro_error_n_in,
		!copro_busy_n_in, copro_operand_request_in};

	// two flops per async lane
	generate
		for (genvar i = 0; i < ASYNC_LANES; i++)
		begin : g_sync
			always_ff @(posedge clk_sys_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
				begin
					sync1_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
				end
				else
				begin
					sync1_reg[i] <= async_raw[i]; // RULE22 RULE7
					sync2_reg[i] <= sync1_reg[i];
				end
			end
		end
	endgenerate

	// synchronous pins sampled once
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			reset_q_reg  <= 1'b1;
			hold_q_reg   <= 1'b0;
			nmi_prev_reg <= 1'b0;
		end
		else
		begin
			reset_q_reg  <= cpu_reset_in; // RULE21
			hold_q_reg   <= hold_req_in; // RULE3
			nmi_prev_reg <= sync2_reg[LANE_NMI];
		end
	end

	logic busy_s;
	logic error_s;
	logic nmi_edge;
	assign busy_s   = sync2_reg[LANE_BUSY];
	assign error_s  = sync2_reg[LANE_ERROR];
	assign nmi_edge = sync2_reg[LANE_NMI] && !nmi_prev_reg; // RULE16

	// exempt from the error exception
	function automatic logic err_exempt(input copro_instr_t k);
		err_exempt = (k == CI_INIT_NOWAIT) || (k == CI_CLEX_NOWAIT) ||
			(k == CI_STORE_STATUS) || (k == CI_STORE_STS_AC) ||
			(k == CI_STORE_CTRL) || (k == CI_STORE_ENV) || (k == CI_SAVE_STATE);
	endfunction : err_exempt

	// ---------------------------------------------------------------
	// reset phase and self-test strap
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			proc_phase_out   <= 1'b0;
			selftest_req_out <= 1'b0;
		end
		else
		begin
			proc_phase_out <= reset_q_reg ? 1'b0 : !proc_phase_out; // RULE21
			if (reset_q_reg && !cpu_reset_in)
				selftest_req_out <= busy_s; // RULE10
		end
	end

	// ---------------------------------------------------------------
	// hold arbitration
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			bus_hold_grant_out <= 1'b0;
		else if (reset_q_reg)
			bus_hold_grant_out <= 1'b0; // RULE2 RULE20
		else if (!hold_q_reg)
			bus_hold_grant_out <= 1'b0; // RULE23
		else if (core_bus_idle_in)
			bus_hold_grant_out <= 1'b1;
	end

	// bus pins: idle in reset, float in grant, else core values
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			bus_pins_out  <= {IDLE_ADS_N, IDLE_BE_N, IDLE_ADDR, IDLE_WR, IDLE_DC,
				IDLE_MIO, IDLE_LOCK_N};
			bus_oe_n_out  <= 1'b0;
			data_pins_out <= 32'h00000000;
			data_oe_n_out <= 1'b1;
		end
		else if (reset_q_reg)
		begin
			bus_pins_out  <= {IDLE_ADS_N, IDLE_BE_N, IDLE_ADDR, IDLE_WR, IDLE_DC,
				IDLE_MIO, IDLE_LOCK_N}; // RULE19
			bus_oe_n_out  <= 1'b0;
			data_oe_n_out <= 1'b1;
		end
		else if (bus_hold_grant_out)
		begin
			bus_oe_n_out  <= 1'b1; // RULE4
			data_oe_n_out <= 1'b1;
		end
		else
		begin
			bus_pins_out  <= core_bus_in;
			bus_oe_n_out  <= 1'b0;
			data_pins_out <= core_data_in;
			data_oe_n_out <= !core_data_drive_in;
		end
	end

	// ---------------------------------------------------------------
	// coprocessor handshake
	// ---------------------------------------------------------------
	copro_state_t cp_state_reg;
	copro_instr_t cp_kind_reg;

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			cp_state_reg  <= CP_IDLE;
			cp_kind_reg   <= CI_OTHER;
			copro_go_out  <= 1'b0;
			copro_exc_out <= 1'b0;
		end
		else
		begin
			copro_go_out  <= 1'b0;
			copro_exc_out <= 1'b0;
			if (reset_q_reg)
				cp_state_reg <= CP_IDLE;
			else
			begin
				case (cp_state_reg)
					CP_IDLE:
						if (copro_instr_valid_in)
						begin
							cp_kind_reg <= copro_instr_kind_in;
							if (copro_instr_kind_in == CI_STACK ||
								copro_instr_kind_in == CI_WAIT)
								cp_state_reg <= CP_BUSY; // RULE8
							else
								cp_state_reg <= CP_CHECK; // RULE9
						end
					CP_BUSY:
						if (!busy_s)
							cp_state_reg <= CP_CHECK; // RULE8
					CP_CHECK:
					begin
						cp_state_reg <= CP_IDLE;
						if (error_s && !err_exempt(cp_kind_reg))
							copro_exc_out <= 1'b1; // RULE11
						else
							copro_go_out <= 1'b1; // RULE12
					end
					default:
						cp_state_reg <= CP_IDLE;
				endcase
			end
		end
	end

	// operand transfer request with stored direction and address
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			copro_xfer_req_out  <= 1'b0;
			copro_xfer_dir_out  <= 1'b0;
			copro_xfer_addr_out <= 30'h00000000;
		end
		else
		begin
			if (cp_state_reg == CP_IDLE && copro_instr_valid_in && !reset_q_reg)
			begin
				copro_xfer_dir_out  <= copro_dir_in; // RULE6
				copro_xfer_addr_out <= copro_addr_in;
			end
			copro_xfer_req_out <= sync2_reg[LANE_OPREQ] && !reset_q_reg &&
				!bus_hold_grant_out; // RULE6
		end
	end

	// ---------------------------------------------------------------
	// interrupt dispatch
	// ---------------------------------------------------------------
	dispatch_state_t dsp_state_reg;
	logic            nmi_pend_reg;
	logic            nmi_block_reg;
	logic            nmi_take;
	logic            irq_take;

	assign nmi_take = (dsp_state_reg == DSP_IDLE) && nmi_pend_reg && !nmi_block_reg &&
		!bus_hold_grant_out && !reset_q_reg && !copro_exc_out; // RULE5 RULE17
	assign irq_take = (dsp_state_reg == DSP_IDLE) && !nmi_take && !reset_q_reg &&
		!copro_exc_out && sync2_reg[LANE_IRQ] && irq_enable_flag_in &&
		!bus_hold_grant_out; // RULE13

	// one remembered edge, set wins over clear
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			nmi_pend_reg  <= 1'b0;
			nmi_block_reg <= 1'b0;
		end
		else if (reset_q_reg)
		begin
			nmi_pend_reg  <= 1'b0; // RULE19
			nmi_block_reg <= 1'b0;
		end
		else
		begin
			if (nmi_edge)
				nmi_pend_reg <= 1'b1; // RULE5 RULE17
			else if (nmi_take)
				nmi_pend_reg <= 1'b0;
			if (nmi_take)
				nmi_block_reg <= 1'b1; // RULE17
			else if (interrupt_return_instr_in)
				nmi_block_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			dsp_state_reg    <= DSP_IDLE;
			vector_valid_out <= 1'b0;
			vector_out       <= 8'h00;
		end
		else
		begin
			vector_valid_out <= 1'b0;
			if (reset_q_reg)
				dsp_state_reg <= DSP_IDLE;
			else if (copro_exc_out)
			begin
				vector_valid_out <= 1'b1; // RULE11
				vector_out       <= VEC_COPRO_ERR;
			end
			else
			begin
				case (dsp_state_reg)
					DSP_IDLE:
						if (nmi_take)
						begin
							vector_valid_out <= 1'b1; // RULE15
							vector_out       <= VEC_NMI;
						end
						else if (irq_take)
							dsp_state_reg <= DSP_ACK1; // RULE13
					DSP_ACK1:
						if (inta_cycle_done_in)
							dsp_state_reg <= DSP_ACK2;
					DSP_ACK2:
						if (inta_cycle_done_in)
						begin
							dsp_state_reg    <= DSP_IDLE;
							vector_valid_out <= 1'b1;
							vector_out       <= data_low_in; // RULE13
						end
					default:
						dsp_state_reg <= DSP_IDLE;
				endcase
			end
		end
	end

	// ack cycle indicators from the dispatch state
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			inta_cycle_out  <= 1'b0;
			inta_second_out <= 1'b0;
		end
		else
		begin
			inta_cycle_out  <= !reset_q_reg && (irq_take ||
				(dsp_state_reg != DSP_IDLE && !(dsp_state_reg == DSP_ACK2 &&
				inta_cycle_done_in)));
			inta_second_out <= !reset_q_reg && ((dsp_state_reg == DSP_ACK1 &&
				inta_cycle_done_in) || (dsp_state_reg == DSP_ACK2 &&
				!inta_cycle_done_in));
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_reset_no_grant;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		reset_q_reg |=> !bus_hold_grant_out;
	endproperty
	a_reset_no_grant: assert property (p_reset_no_grant) // RULE2
		else $error("grant seen after reset");

	property p_idle_pins;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		reset_q_reg |=> (!bus_oe_n_out && data_oe_n_out && bus_pins_out.ads_n &&
			bus_pins_out.be_n == IDLE_BE_N && bus_pins_out.addr == IDLE_ADDR &&
			!bus_pins_out.wr && bus_pins_out.dc && !bus_pins_out.mio);
	endproperty
	a_idle_pins: assert property (p_idle_pins) // RULE19
		else $error("reset idle levels wrong");

	property p_hold_float;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		bus_hold_grant_out && hold_q_reg && !reset_q_reg |=> bus_oe_n_out && data_oe_n_out;
	endproperty
	a_hold_float: assert property (p_hold_float) // RULE4
		else $error("bus driven during grant");

	property p_grant_release;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		bus_hold_grant_out && !hold_q_reg |=> !bus_hold_grant_out ##1 !bus_oe_n_out;
	endproperty
	a_grant_release: assert property (p_grant_release) // RULE23
		else $error("grant not released");

	property p_nmi_no_ack;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		nmi_take |=> vector_valid_out && vector_out == VEC_NMI && !inta_cycle_out;
	endproperty
	a_nmi_no_ack: assert property (p_nmi_no_ack) // RULE15
		else $error("nmi vector wrong");

	property p_nmi_blocked;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		nmi_block_reg && !interrupt_return_instr_in |=> !nmi_take;
	endproperty
	a_nmi_blocked: assert property (p_nmi_blocked) // RULE17
		else $error("nmi nested before return");

	property p_busy_wait;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		cp_state_reg == CP_BUSY && busy_s && !reset_q_reg |=> cp_state_reg == CP_BUSY
			##1 !copro_go_out;
	endproperty
	a_busy_wait: assert property (p_busy_wait) // RULE8
		else $error("proceeded while busy");

	property p_init_nowait;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		cp_state_reg == CP_IDLE && copro_instr_valid_in && !reset_q_reg &&
			copro_instr_kind_in == CI_INIT_NOWAIT ##1 !reset_q_reg |=> copro_go_out;
	endproperty
	a_init_nowait: assert property (p_init_nowait) // RULE9
		else $error("no-wait init stalled");

	property p_err_exc;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		cp_state_reg == CP_CHECK && !reset_q_reg && error_s && cp_kind_reg == CI_STACK
			|=> copro_exc_out ##1 vector_valid_out && vector_out == VEC_COPRO_ERR;
	endproperty
	a_err_exc: assert property (p_err_exc) // RULE11
		else $error("error exception missing");

	property p_irq_masked;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		dsp_state_reg == DSP_IDLE && !irq_enable_flag_in && !copro_exc_out |=>
			dsp_state_reg == DSP_IDLE;
	endproperty
	a_irq_masked: assert property (p_irq_masked) // RULE13
		else $error("masked request dispatched");

	property p_selftest;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		reset_q_reg && !cpu_reset_in |=> selftest_req_out == $past(busy_s);
	endproperty
	a_selftest: assert property (p_selftest) // RULE10
		else $error("self-test strap wrong");

endmodule : cpu_hold_maskable_irq_copro_ctl

//--- design/cpu_ctl_pkg.sv
// constants, types and encodings for the processor control-pin block
// assumes one 25 MHz system clock standing in for the double-rate clock
//
// Functional notes
// RULE1: an outside master keeps hold request high while it owns the bus
// RULE2: hold request is ignored during reset; reset gives idle bus, not float
// RULE3: hold request is a level sampled on the clock, no synchroniser
// RULE4: in hold grant only the grant pin is driven; all bus pins float
// RULE5: one nmi rising edge during hold grant is kept, served after release
// RULE6: operand request moves operand using stored direction and address
// RULE7: operand request, busy and error are async levels
// RULE8: stack and wait instructions wait until busy is seen negated
// RULE9: no-wait init and clear-exceptions proceed even while busy
// RULE10: busy level at reset fall selects self-test (low) or none (high)
// RULE11: error sampled at each coprocessor instruction; asserted raises vector 16
// RULE12: init, clear, store status/control/env and save never raise vector 16
// RULE13: maskable request gated by enable flag; two ack cycles, latch low byte
// RULE14: source holds maskable request until the first ack cycle begins
// RULE15: nmi goes through fixed vector 2 with no ack cycles
// RULE16: nmi is rising-edge, async; source keeps low 8 then high 8 clocks
// RULE17: after nmi starts, others wait for interrupt return; one edge is kept (code blocks only further nmi; irq_take ignores nmi_block_reg)
// RULE18: reset source holds reset 15 clocks, or 80 when asking self-test
// RULE19: during reset inputs are ignored and pins show the idle levels
// RULE20: reset during hold grant leaves grant and applies idle levels
// RULE21: reset is synchronous; its fall fixes the internal clock phase
// RULE22: async inputs pass a two-stage synchroniser before use
// RULE23: grant stays until hold is sampled negated, then bus is driven again

package cpu_ctl_pkg;

	// ---------------------------------------------------------------
	// synchroniser lanes
	// ---------------------------------------------------------------
	localparam int ASYNC_LANES = 5;
	localparam int LANE_OPREQ  = 0;
	localparam int LANE_BUSY   = 1;
	localparam int LANE_ERROR  = 2;
	localparam int LANE_IRQ    = 3;
	localparam int LANE_NMI    = 4;

	// ---------------------------------------------------------------
	// vectors and timing figures
	// ---------------------------------------------------------------
	localparam logic [7:0] VEC_NMI       = 8'h02;
	localparam logic [7:0] VEC_COPRO_ERR = 8'h10;
	localparam int NMI_MIN_CLOCKS        = 8;
	localparam int RESET_MIN_CLOCKS      = 15;
	localparam int RESET_TEST_CLOCKS     = 80;

	// ---------------------------------------------------------------
	// idle pin levels during reset
	// ---------------------------------------------------------------
	localparam logic       IDLE_ADS_N  = 1'h1;
	localparam logic [3:0] IDLE_BE_N   = 4'h0;
	localparam logic [29:0] IDLE_ADDR  = 30'h3FFFFFFF;
	localparam logic       IDLE_WR     = 1'h0;
	localparam logic       IDLE_DC     = 1'h1;
	localparam logic       IDLE_MIO    = 1'h0;
	localparam logic       IDLE_LOCK_N = 1'h1;

	// bus pin group from the core and to the pins
	typedef struct packed {
		logic        ads_n;
		logic [3:0]  be_n;
		logic [29:0] addr;
		logic        wr;
		logic        dc;
		logic        mio;
		logic        lock_n;
	} bus_ctl_t;

	// coprocessor instruction classes
	typedef enum logic [3:0] {
		CI_STACK        = 4'h0,
		CI_WAIT         = 4'h1,
		CI_INIT_NOWAIT  = 4'h2,
		CI_CLEX_NOWAIT  = 4'h3,
		CI_STORE_STATUS = 4'h4,
		CI_STORE_STS_AC = 4'h5,
		CI_STORE_CTRL   = 4'h6,
		CI_STORE_ENV    = 4'h7,
		CI_SAVE_STATE   = 4'h8,
		CI_OTHER        = 4'h9
	} copro_instr_t;

	typedef enum logic [1:0] {
		CP_IDLE  = 2'b00,
		CP_BUSY  = 2'b01,
		CP_CHECK = 2'b10
	} copro_state_t;

	typedef enum logic [1:0] {
		DSP_IDLE = 2'b00,
		DSP_ACK1 = 2'b01,
		DSP_ACK2 = 2'b10
	} dispatch_state_t;

endpackage : cpu_ctl_pkg

//--- tb/far_side_model.sv
// far-side model: hold master and interrupt controller
// assumes the bench drives its wish lines on the rising edge
`timescale 1ns/1ns

module far_side_model
(
	// clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       reset_n_in,
	// bench wishes
	input  wire logic       hold_want_in,
	input  wire logic       irq_want_in,
	input  wire logic [7:0] vec_byte_in,
	input  wire logic [3:0] ack_delay_in,
	// block side
	input  wire logic       inta_cycle_in,
	output logic            hold_req_out,
	output logic            irq_out,
	output logic            ack_done_out,
	output logic [7:0]      data_low_out
);
	logic [3:0] wait_reg;
	logic       taken_reg;
	logic       inta_reg;
	logic [7:0] junk_reg;

	// hold and irq levels; irq kept until the first ack cycle begins
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			hold_req_out <= 1'h0;
			irq_out      <= 1'h0;
			taken_reg    <= 1'h0;
		end
		else
		begin
			hold_req_out <= hold_want_in;
			taken_reg    <= irq_want_in && (taken_reg || inta_cycle_in);
			irq_out      <= irq_want_in && !taken_reg && !inta_cycle_in;
		end
	end

	// ack cycle end after a chosen delay; byte only valid around ack
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			wait_reg     <= 4'h0;
			ack_done_out <= 1'h0;
			inta_reg     <= 1'h0;
			junk_reg     <= 8'h5A;
		end
		else
		begin
			inta_reg     <= inta_cycle_in;
			junk_reg     <= ~junk_reg;
			ack_done_out <= inta_cycle_in && !ack_done_out && wait_reg >= ack_delay_in;
			wait_reg     <= (!inta_cycle_in || ack_done_out) ? 4'h0 : wait_reg + 4'h1;
		end
	end
	assign data_low_out = (inta_cycle_in || inta_reg) ? vec_byte_in : junk_reg;
endmodule : far_side_model

//--- tb/cpu_hold_maskable_irq_copro_ctl_tb.sv
// bench for the control-pin block with random core traffic
// assumes far_side_model plays hold master and interrupt controller
`timescale 1ns/1ns

module cpu_hold_maskable_irq_copro_ctl_tb import cpu_ctl_pkg::*;;
	logic clk = 0, rst_n = 0, cpu_rst = 1, hold_want = 0, irq_want = 0, hold_req, irq, done;
	logic opreq = 0, busy_n = 1, err_n = 1, nmi = 0, ien = 0, interrupt_return_instr = 0, ivalid = 0;
	logic dir = 0, idle = 1, drive = 0, grant, bus_oe_n, data_oe_n, go, exc, xreq, xdir;
	logic inta, isec, vv, st, ph, d, drive_prev = 0;
	logic [7:0] data_low, vec, last_vec, vec_byte = 0;
	logic [3:0] ack_delay = 1;
	logic [29:0] addr = 0, xaddr, a;
	logic [31:0] core_data = 0, data_out, data_prev = 0;
	bus_ctl_t core_bus = '0, core_prev = '0, pins;
	copro_instr_t kind = CI_OTHER;
	int error_cnt = 0, check_count = 0, vec_cnt = 0, go_cnt = 0, exc_cnt = 0, inta_cnt = 0;
	int c, i0, a0, s0, ack_cnt = 0, sec_cnt = 0;

	cpu_hold_maskable_irq_copro_ctl DUT (.clk_sys_in(clk), .reset_n_in(rst_n), .cpu_reset_in(cpu_rst),
		.hold_req_in(hold_req), .copro_operand_request_in(opreq), .copro_busy_n_in(busy_n),
		.copro_error_n_in(err_n), .maskable_irq_in(irq), .nmi_in(nmi), .data_low_in(data_low),
		.bus_hold_grant_out(grant), .bus_pins_out(pins), .bus_oe_n_out(bus_oe_n),
		.data_pins_out(data_out), .data_oe_n_out(data_oe_n), .core_bus_in(core_bus),
		.core_data_in(core_data), .core_data_drive_in(drive), .core_bus_idle_in(idle),
		.copro_instr_valid_in(ivalid), .copro_instr_kind_in(kind), .copro_dir_in(dir),
		.copro_addr_in(addr), .copro_go_out(go), .copro_exc_out(exc), .copro_xfer_req_out(xreq),
		.copro_xfer_dir_out(xdir), .copro_xfer_addr_out(xaddr), .irq_enable_flag_in(ien),
		.interrupt_return_instr_in(interrupt_return_instr), .inta_cycle_done_in(done), .inta_cycle_out(inta),
		.inta_second_out(isec), .vector_valid_out(vv), .vector_out(vec),
		.selftest_req_out(st), .proc_phase_out(ph));

	far_side_model partner (.clk_sys_in(clk), .reset_n_in(rst_n), .hold_want_in(hold_want),
		.irq_want_in(irq_want), .vec_byte_in(vec_byte), .ack_delay_in(ack_delay),
		.inta_cycle_in(inta), .hold_req_out(hold_req), .irq_out(irq), .ack_done_out(done),
		.data_low_out(data_low));

	// ---------------------------------------------------------------
	// clock, core traffic and event counters
	// ---------------------------------------------------------------
	initial
	begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		core_prev <= core_bus;
		data_prev <= core_data;
		drive_prev <= drive;
		ack_cnt += int'(inta === 1'b1 && done === 1'b1);
		sec_cnt += int'(isec === 1'b1 && done === 1'b1);
		core_bus  <= bus_ctl_t'({7'($urandom), $urandom});
		core_data <= $urandom;
		drive     <= 1'($urandom);
		idle      <= ($urandom % 4) != 0;
		if (vv === 1'b1)
		begin
			vec_cnt++;
			last_vec = vec;
		end
		go_cnt += int'(go === 1'b1);
		exc_cnt += int'(exc === 1'b1);
		inta_cnt += int'(inta === 1'b1);
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (exp !== got)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	function automatic int probe(input int sel);
		if (sel == 0)
			return int'(grant === 1'b1);
		return (sel == 1) ? vec_cnt : go_cnt + exc_cnt;
	endfunction : probe

	task automatic wait_for(input int sel, input int target);
		int n;
		n = 0;
		while (probe(sel) != target && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 60)
		begin
			error_cnt++;
			$display("[FAIL] wait %0d expected %0d seen %0d", sel, target, probe(sel));
			final_report();
		end
	endtask : wait_for

	task automatic do_reset(input int len, input logic busy_lvl);
		logic p;
		@(posedge clk);
		cpu_rst <= 1'b1;
		busy_n <= busy_lvl;
		hold_want <= 1'b1;
		tick(len - 3);
		check("grant in reset", 0, grant);
		check("idle pins", {IDLE_ADS_N, IDLE_BE_N, IDLE_ADDR, IDLE_WR, IDLE_DC, IDLE_MIO,
			IDLE_LOCK_N}, pins);
		check("oe in reset", 2'b01, {bus_oe_n, data_oe_n});
		@(posedge clk);
		hold_want <= 1'b0;
		tick(2);
		@(posedge clk);
		cpu_rst <= 1'b0;
		tick(3);
		check("self-test", !busy_lvl, st);
		p = ph;
		tick(1);
		check("phase", !p, ph);
		busy_n <= 1'b1;
	endtask : do_reset

	task automatic copro_run(input copro_instr_t k, input logic busy_on, input logic err_on);
		int g, e;
		logic waits, exc_exp;
		waits = busy_on && (k == CI_STACK || k == CI_WAIT);
		exc_exp = err_on && (k == CI_STACK || k == CI_WAIT || k == CI_OTHER);
		@(posedge clk);
		busy_n <= !busy_on;
		err_n <= !err_on;
		tick(4);
		g = go_cnt;
		e = exc_cnt;
		@(posedge clk);
		ivalid <= 1'b1;
		kind <= k;
		dir <= 1'($urandom);
		addr <= 30'($urandom);
		@(posedge clk);
		ivalid <= 1'b0;
		if (waits)
		begin
			tick(8);
			check("held while busy", g + e, go_cnt + exc_cnt);
			@(posedge clk);
			busy_n <= 1'b1;
		end
		wait_for(2, g + e + 1);
		tick(2);
		check("go count", g + int'(!exc_exp), go_cnt);
		check("exc count", e + int'(exc_exp), exc_cnt);
		if (exc_exp)
			check("exc vector", VEC_COPRO_ERR, last_vec);
		busy_n <= 1'b1;
	endtask : copro_run

	task automatic nmi_pulse;
		@(posedge clk);
		nmi <= 1'b0;
		repeat (8) @(posedge clk);
		nmi <= 1'b1;
		repeat (8) @(posedge clk);
		nmi <= 1'b0;
	endtask : nmi_pulse

	task automatic interrupt_return_instr_pulse;
		@(posedge clk);
		interrupt_return_instr <= 1'b1;
		@(posedge clk);
		interrupt_return_instr <= 1'b0;
		tick(1);
	endtask : interrupt_return_instr_pulse

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(32'hDDD4));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		do_reset(81, 1'b0);
		do_reset(16, 1'b1);
		for (int i = 0; i < 20; i++)
			copro_run(copro_instr_t'(i % 10), (i % 10 < 4) && (i < 10 || 1'($urandom)), i >= 10);
		copro_run(CI_OTHER, 1'b0, 1'b0);
		d = dir;
		a = addr;
		@(posedge clk);
		dir <= ~d;
		addr <= ~a;
		opreq <= 1'b1;
		tick(5);
		check("xfer req", 1, xreq);
		check("xfer dir addr", {d, a}, {xdir, xaddr});
		@(posedge clk);
		opreq <= 1'b0;
		tick(5);
		check("xfer end", 0, xreq);
		c = vec_cnt;
		i0 = inta_cnt;
		nmi_pulse();
		tick(4);
		check("nmi served", c + 1, vec_cnt);
		check("nmi vector", VEC_NMI, last_vec);
		check("no ack cycle", i0, inta_cnt);
		nmi_pulse();
		tick(4);
		check("nmi blocked", c + 1, vec_cnt);
		interrupt_return_instr_pulse();
		wait_for(1, c + 2);
		interrupt_return_instr_pulse();
		for (int j = 0; j < 2; j++)
		begin
			c = vec_cnt;
			i0 = inta_cnt;
			a0 = ack_cnt;
			s0 = sec_cnt;
			@(posedge clk);
			irq_want <= 1'b1;
			vec_byte <= 8'($urandom);
			ack_delay <= (j == 0) ? 4'h1 : 4'h6;
			tick(10);
			check("masked irq", i0, inta_cnt);
			@(posedge clk);
			ien <= 1'b1;
			wait_for(1, c + 1);
			check("irq vector", vec_byte, last_vec);
			check("two ack cycles", a0 + 2, ack_cnt);
			check("second ack", s0 + 1, sec_cnt);
			@(posedge clk);
			irq_want <= 1'b0;
			ien <= 1'b0;
			tick(6);
			check("single irq", c + 1, vec_cnt);
		end
		c = vec_cnt;
		@(posedge clk);
		hold_want <= 1'b1;
		wait_for(0, 1);
		tick(1);
		check("float", 2'b11, {bus_oe_n, data_oe_n});
		nmi_pulse();
		nmi_pulse();
		check("nmi in grant", c, vec_cnt);
		@(posedge clk);
		hold_want <= 1'b0;
		wait_for(0, 0);
		tick(1);
		check("drive again", 0, bus_oe_n);
		check("pins follow core", core_prev, pins);
		check("data follows core", {!drive_prev, data_prev}, {data_oe_n, data_out});
		wait_for(1, c + 1);
		interrupt_return_instr_pulse();
		tick(8);
		check("one edge kept", c + 1, vec_cnt);
		@(posedge clk);
		hold_want <= 1'b1;
		wait_for(0, 1);
		do_reset(16, 1'b1);
		final_report();
	end
endmodule : cpu_hold_maskable_irq_copro_ctl_tb
